// [rtl/mtr_crc16.sv]
// Byte-wide CRC-16 accumulator for the typed Modbus register handler
`timescale 1ns/1ps
module mtr_crc16
    import mtr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [15:0] crc,
    output logic [15:0] crc_next
);
    logic [15:0] crc_reg;
    logic [15:0] step;

    // Fold one byte in, LSB first
    always_comb begin
        step = crc_reg ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            step = step[0] ? ((step >> 1) ^ CRC_POLY) : (step >> 1);
        end
        crc_next = clr ? CRC_INIT : (en ? step : crc_reg);
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_reg <= CRC_INIT;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule : mtr_crc16

// [rtl/mtr_handler.sv]
// Typed Modbus register request handler: decode, convert, answer
//
// Notes on behaviour
// - Address bits 15-14 select 16/32/float/reserved
// - Start address type applies to whole block
// - Float type is IEEE754, support is optional
// - 32-bit values use two registers, MSW first
// - 16-bit read of 32-bit parameter: low word
// - 32-bit read of 16-bit parameter: sign-extended
// - Odd count on 32-bit access gives exception 2
// - 32-bit write to 16-bit needs in-range value
// - 16-bit write to 32-bit is sign-extended
// - Detectable errors get an exception response
// - Corrupt or bad-CRC frames get no reply
// - Oversized write blocks dropped silently
// - Exception: node, code|0x80, exception, CRC
// - Code 1 bad function, code 2 bad address
// - CRC-16 x16+x15+x2+1 over all bytes
// - CRC appended low byte first
// - Block write stops at first failure, counts
`timescale 1ns/1ps
module mtr_handler
    import mtr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] node_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic frame_end,
    input wire logic frame_err,
    input wire logic tx_ready,
    input wire logic param_ack,
    input wire logic param_fail,
    input wire logic param_is32,
    input wire logic [31:0] param_rd_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic param_rd,
    output logic param_wr,
    output logic [13:0] param_index,
    output logic [31:0] param_wr_data,
    output logic param_wide,
    output logic param_float
);
    // ------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------
    logic [7:0] rbuf_reg [BUF_BYTES];
    logic [7:0] rbuf_next [BUF_BYTES];
    logic [7:0] rcnt_reg, rcnt_next;
    logic rovf_reg, rovf_next, rbad_reg, rbad_next;
    logic rx_clr, frame_good;
    logic [15:0] rx_crc;
    mtr_state_e state_reg, state_next;

    // Collect bytes while idle; overflow and line errors are remembered
    always_comb begin
        rbuf_next = rbuf_reg;
        rcnt_next = rcnt_reg;
        rovf_next = rovf_reg;
        rbad_next = rbad_reg;
        if (rx_clr) begin
            rcnt_next = 8'h00;
            rovf_next = 1'b0;
            rbad_next = 1'b0;
        end else if (state_reg == S_IDLE) begin
            if (rx_valid) begin
                if (rcnt_reg < 8'(BUF_BYTES)) begin
                    rbuf_next[rcnt_reg[IDX_W-1:0]] = rx_data;
                end else begin
                    rovf_next = 1'b1;
                end
                if (rcnt_reg != 8'hFF) begin
                    rcnt_next = rcnt_reg + 8'h01;
                end
            end
            if (frame_err) begin
                rbad_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rcnt_reg <= 8'h00;
            rovf_reg <= 1'b0;
            rbad_reg <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_next;
            rovf_reg <= rovf_next;
            rbad_reg <= rbad_next;
        end
        rbuf_reg <= rbuf_next;
    end

    // Residue over every byte including the CRC must be zero
    mtr_crc16 u_rx_crc (
        .clk(clk),
        .rst(rst),
        .clr(rx_clr),
        .en(state_reg == S_IDLE && rx_valid && !rx_clr),
        .data(rx_data),
        .crc(rx_crc),
        .crc_next()
    );
    assign frame_good = !rbad_reg && !frame_err && rcnt_reg >= MIN_FRAME
                        && rx_crc == CRC_GOOD;

    // ------------------------------------------------------------------
    // Request fields
    // ------------------------------------------------------------------
    logic [7:0] fc;
    logic [15:0] req_addr, req_cnt;
    logic [1:0] typ;
    logic typ_wide, bad_type, for_us;
    assign fc = rbuf_reg[1];
    assign req_addr = {rbuf_reg[2], rbuf_reg[3]};
    assign req_cnt = {rbuf_reg[4], rbuf_reg[5]};
    assign typ = req_addr[TYPE_HI:TYPE_LO];
    assign typ_wide = typ != TYPE_INT16;
    assign bad_type = typ == TYPE_RSVD || (typ == TYPE_FLOAT && !FLOAT_SUPPORTED);
    assign for_us = rbuf_reg[0] == node_addr || rbuf_reg[0] == BCAST_ADDR;

    // ------------------------------------------------------------------
    // Control, parameter access and transmit
    // ------------------------------------------------------------------
    mtr_resp_e kind_reg, kind_next;
    logic [7:0] exc_reg, exc_next, nparam_reg, nparam_next, pidx_reg, pidx_next;
    logic [7:0] tx_idx_reg, tx_idx_next, tx_len_reg, tx_len_next, step, wpos, sel_n, sel;
    logic [13:0] base_reg, base_next;
    logic [15:0] done_reg, done_next, tx_crc, tx_crc_next;
    logic wide_reg, wide_next, flt_reg, flt_next, bcast_reg, bcast_next, fin;
    logic [7:0] tbuf_reg [BUF_BYTES];
    logic [7:0] tbuf_next [BUF_BYTES];
    logic [IDX_W-1:0] rd_pos;
    logic [31:0] rd_word, wr_word;
    logic tx_valid_next, param_rd_next, param_wr_next, tx_acc;
    logic [7:0] tx_data_next, rd_lo_byte;

    assign step = wide_reg ? 8'h04 : 8'h02;
    assign rd_pos = IDX_W'(pidx_reg * step);
    assign wpos = (fc == FC_WR_SINGLE) ? WS_DATA_POS : 8'(WR_DATA_POS + pidx_reg * step);
    // 16-bit parameter read as 32-bit is sign-extended; narrow keeps low word
    assign rd_word = param_is32 ? param_rd_data
                     : {{16{param_rd_data[15]}}, param_rd_data[15:0]};
    assign rd_lo_byte = param_rd_data[7:0];
    assign wr_word = wide_reg
        ? {rbuf_reg[wpos[IDX_W-1:0]], rbuf_reg[IDX_W'(wpos + 8'h01)],
           rbuf_reg[IDX_W'(wpos + 8'h02)], rbuf_reg[IDX_W'(wpos + 8'h03)]}
        : {{16{rbuf_reg[wpos[IDX_W-1:0]][7]}}, rbuf_reg[wpos[IDX_W-1:0]],
           rbuf_reg[IDX_W'(wpos + 8'h01)]};
    assign tx_acc = state_reg == S_TX && tx_valid && tx_ready;
    assign rx_clr = state_next == S_IDLE && (state_reg != S_IDLE || frame_end);

    mtr_crc16 u_tx_crc (
        .clk(clk),
        .rst(rst),
        .clr(fin),
        .en(tx_acc && tx_idx_reg < tx_len_reg),
        .data(tx_data),
        .crc(tx_crc),
        .crc_next(tx_crc_next)
    );

    // Response byte for the position after the current one
    always_comb begin
        sel_n = (state_reg == S_TX) ? tx_idx_reg + 8'h01 : 8'h00;
        sel = 8'h00;
        if (sel_n == 8'h00) begin
            sel = node_addr;
        end else if (sel_n == 8'h01) begin
            sel = (kind_reg == R_EXC) ? (fc | EXC_FLAG) : fc;
        end else begin
            unique case (kind_reg)
                R_EXC: sel = exc_reg;
                R_READ: sel = (sel_n == 8'h02) ? {nparam_reg[5:0], 2'b00} >> !wide_reg
                                               : tbuf_reg[IDX_W'(sel_n - RD_HDR)];
                R_ECHO: sel = rbuf_reg[sel_n[IDX_W-1:0]];
                R_WRITTEN: sel = (sel_n == 8'h04) ? done_reg[15:8]
                               : (sel_n == 8'h05) ? done_reg[7:0] : rbuf_reg[sel_n[IDX_W-1:0]];
            endcase
        end
    end

    // Next-state logic for the request sequence
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        exc_next = exc_reg;
        nparam_next = nparam_reg;
        pidx_next = pidx_reg;
        base_next = base_reg;
        done_next = done_reg;
        wide_next = wide_reg;
        flt_next = flt_reg;
        bcast_next = bcast_reg;
        tbuf_next = tbuf_reg;
        tx_idx_next = tx_idx_reg;
        tx_len_next = tx_len_reg;
        tx_valid_next = tx_valid;
        tx_data_next = tx_data;
        param_rd_next = 1'b0;
        param_wr_next = 1'b0;
        fin = 1'b0;
        unique case (state_reg)
            S_IDLE: begin
                if (frame_end && frame_good) begin
                    state_next = S_DECODE;
                end
            end
            S_DECODE: begin
                bcast_next = rbuf_reg[0] == BCAST_ADDR;
                base_next = req_addr[13:0];
                wide_next = typ_wide && fc != FC_WR_SINGLE;
                flt_next = typ == TYPE_FLOAT;
                nparam_next = typ_wide ? req_cnt[8:1] : req_cnt[7:0];
                pidx_next = 8'h00;
                done_next = 16'h0000;
                exc_next = EXC_BAD_ADDR;
                kind_next = R_EXC;
                if (!for_us || (fc == FC_WR_MULTI && rovf_reg)) begin
                    state_next = S_IDLE;
                end else if (fc != FC_RD_MULTI && fc != FC_WR_SINGLE && fc != FC_WR_MULTI) begin
                    exc_next = EXC_BAD_FC;
                    fin = 1'b1;
                end else if (bad_type) begin
                    fin = 1'b1;
                end else if (fc == FC_WR_SINGLE) begin
                    nparam_next = 8'h01;
                    if (rcnt_reg == FIXED_FRAME) state_next = S_WR_REQ;
                    else fin = 1'b1;
                end else if (req_cnt == 16'h0000 || (typ_wide && req_cnt[0])) begin
                    fin = 1'b1;
                end else if (fc == FC_RD_MULTI) begin
                    if (rcnt_reg == FIXED_FRAME && req_cnt <= MAX_RD_REGS) state_next = S_RD_REQ;
                    else fin = 1'b1;
                end else if (req_cnt[15:7] == 9'h000 && {req_cnt[6:0], 1'b0} == rbuf_reg[6]
                             && rcnt_reg == 8'(WM_HDR + rbuf_reg[6])) begin
                    state_next = S_WR_REQ;
                end else begin
                    fin = 1'b1;
                end
            end
            S_RD_REQ: begin
                param_rd_next = 1'b1;
                state_next = S_RD_WAIT;
            end
            S_RD_WAIT: begin
                if (param_ack && param_fail) begin
                    kind_next = R_EXC;
                    fin = 1'b1;
                end else if (param_ack) begin
                    // Wide: four bytes MSB first; narrow: low word only
                    for (int k = 0; k < 4; k++) begin
                        if (8'(k) < step) begin
                            tbuf_next[rd_pos + IDX_W'(k)] = wide_reg ? rd_word[31-8*k -: 8]
                                                                     : rd_word[15-8*k -: 8];
                        end
                    end
                    pidx_next = pidx_reg + 8'h01;
                    kind_next = R_READ;
                    fin = pidx_reg + 8'h01 == nparam_reg;
                    state_next = fin ? S_RD_WAIT : S_RD_REQ;
                end
            end
            S_WR_REQ: begin
                param_wr_next = 1'b1;
                state_next = S_WR_WAIT;
            end
            S_WR_WAIT: begin
                if (param_ack) begin
                    kind_next = (fc == FC_WR_SINGLE) ? R_ECHO : R_WRITTEN;
                    if (param_fail) begin
                        if (fc == FC_WR_SINGLE) kind_next = R_EXC;
                        fin = 1'b1;
                    end else begin
                        pidx_next = pidx_reg + 8'h01;
                        done_next = done_reg + (wide_reg ? 16'h0002 : 16'h0001);
                        fin = pidx_reg + 8'h01 == nparam_reg;
                        state_next = fin ? S_WR_WAIT : S_WR_REQ;
                    end
                end
            end
            S_TX: begin
                if (tx_acc) begin
                    tx_idx_next = tx_idx_reg + 8'h01;
                    if (tx_idx_reg + 8'h01 < tx_len_reg) begin
                        tx_data_next = sel;
                    end else if (tx_idx_reg + 8'h01 == tx_len_reg) begin
                        tx_data_next = tx_crc_next[7:0];
                    end else if (tx_idx_reg == tx_len_reg) begin
                        tx_data_next = tx_crc[15:8];
                    end else begin
                        tx_valid_next = 1'b0;
                        state_next = S_IDLE;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
        // Start the answer; broadcasts are never answered
        if (fin) begin
            state_next = bcast_next ? S_IDLE : S_TX;
            tx_valid_next = !bcast_next;
            tx_data_next = node_addr;
            tx_idx_next = 8'h00;
            unique case (kind_next)
                R_EXC: tx_len_next = EXC_LEN;
                R_READ: tx_len_next = 8'(RD_HDR + ({nparam_reg[5:0], 2'b00} >> !wide_reg));
                default: tx_len_next = ECHO_LEN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            kind_reg <= R_EXC;
            exc_reg <= 8'h00;
            nparam_reg <= 8'h00;
            pidx_reg <= 8'h00;
            base_reg <= 14'h0000;
            done_reg <= 16'h0000;
            wide_reg <= 1'b0;
            flt_reg <= 1'b0;
            bcast_reg <= 1'b0;
            tx_idx_reg <= 8'h00;
            tx_len_reg <= 8'h00;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            param_rd <= 1'b0;
            param_wr <= 1'b0;
            param_index <= 14'h0000;
            param_wr_data <= 32'h00000000;
            param_wide <= 1'b0;
            param_float <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            exc_reg <= exc_next;
            nparam_reg <= nparam_next;
            pidx_reg <= pidx_next;
            base_reg <= base_next;
            done_reg <= done_next;
            wide_reg <= wide_next;
            flt_reg <= flt_next;
            bcast_reg <= bcast_next;
            tx_idx_reg <= tx_idx_next;
            tx_len_reg <= tx_len_next;
            tx_valid <= tx_valid_next;
            tx_data <= tx_data_next;
            param_rd <= param_rd_next;
            param_wr <= param_wr_next;
            param_index <= base_reg + 14'(pidx_reg);
            param_wr_data <= wr_word;
            param_wide <= wide_reg;
            param_float <= flt_reg;
        end
        tbuf_reg <= tbuf_next;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    block_type_a: assert property (param_rd |-> param_wide == (rbuf_reg[2][7:6] != TYPE_INT16))
        else $error("access width differs from start address type");
    odd_count_a: assert property (state_reg == S_DECODE && for_us && fc == FC_RD_MULTI
        && !bad_type && typ_wide && req_cnt[0] |=> kind_reg == R_EXC && exc_reg == EXC_BAD_ADDR
        && (bcast_reg || state_reg == S_TX))
        else $error("odd count on wide read not rejected with code 2");
    crc_silent_a: assert property (state_reg == S_IDLE && frame_end && rx_crc != CRC_GOOD
        |=> state_reg == S_IDLE && !tx_valid)
        else $error("reply to frame with bad CRC");
    ovf_silent_a: assert property (state_reg == S_DECODE && for_us && fc == FC_WR_MULTI
        && rovf_reg |=> state_reg == S_IDLE ##1 !tx_valid)
        else $error("oversized write block not dropped");
    exc_fc_a: assert property (tx_valid && kind_reg == R_EXC && tx_idx_reg == 8'h01
        |-> tx_data == (rbuf_reg[1] | EXC_FLAG) && tx_len_reg == EXC_LEN)
        else $error("exception frame malformed");
    bad_fc_a: assert property (state_reg == S_DECODE && for_us && !rovf_reg
        && fc != FC_RD_MULTI && fc != FC_WR_SINGLE && fc != FC_WR_MULTI
        |=> exc_reg == EXC_BAD_FC)
        else $error("unsupported function not given code 1");
    low_word_a: assert property (state_reg == S_RD_WAIT && param_ack && !param_fail
        && !wide_reg |=> tbuf_reg[$past(rd_pos) + 6'h01] == $past(rd_lo_byte))
        else $error("narrow read did not return low word");
    sext_read_a: assert property (state_reg == S_RD_WAIT && param_ack && !param_fail
        && wide_reg && !param_is32 && param_rd_data[15]
        |=> tbuf_reg[$past(rd_pos)] == 8'hFF)
        else $error("wide read of narrow parameter not sign-extended");
    sext_write_a: assert property (param_wr && !param_wide
        |-> param_wr_data[31:16] == {16{param_wr_data[15]}})
        else $error("narrow write not sign-extended");
    wr_stop_a: assert property (state_reg == S_WR_WAIT && param_ack && param_fail
        && fc == FC_WR_MULTI |=> kind_reg == R_WRITTEN && !param_wr [*2])
        else $error("block write continued after failure");
    crc_hi_a: assert property (tx_acc && tx_idx_reg == tx_len_reg
        |=> tx_data == $past(tx_crc[15:8]))
        else $error("CRC high byte not sent last");

    read_wide_c: cover property (state_reg == S_TX && kind_reg == R_READ && wide_reg);
    exc_sent_c: cover property (state_reg == S_TX && kind_reg == R_EXC);
    wr_short_c: cover property (state_reg == S_WR_WAIT && param_ack && param_fail
        && fc == FC_WR_MULTI);
endmodule : mtr_handler

// [rtl/mtr_pkg.sv]
// Shared constants and types for the typed Modbus register request handler
package mtr_pkg;
    // ------------------------------------------------------------------
    // Buffer sizes and frame lengths
    // ------------------------------------------------------------------
    localparam int BUF_BYTES = 64;
    localparam int IDX_W = 6;
    localparam logic [7:0] MIN_FRAME = 8'h04;
    localparam logic [7:0] FIXED_FRAME = 8'h08;
    localparam logic [7:0] WM_HDR = 8'h09;
    localparam logic [7:0] EXC_LEN = 8'h03;
    localparam logic [7:0] RD_HDR = 8'h03;
    localparam logic [7:0] ECHO_LEN = 8'h06;
    localparam logic [7:0] WR_DATA_POS = 8'h07;
    localparam logic [7:0] WS_DATA_POS = 8'h04;
    localparam logic [15:0] MAX_RD_REGS = 16'h001E;
    // ------------------------------------------------------------------
    // Function codes, exception codes, node addressing
    // ------------------------------------------------------------------
    localparam logic [7:0] FC_RD_MULTI = 8'h03;
    localparam logic [7:0] FC_WR_SINGLE = 8'h06;
    localparam logic [7:0] FC_WR_MULTI = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_FC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    // ------------------------------------------------------------------
    // Type selector in register address bits 15-14
    // ------------------------------------------------------------------
    localparam int TYPE_HI = 15;
    localparam int TYPE_LO = 14;
    localparam logic [1:0] TYPE_INT16 = 2'h0;
    localparam logic [1:0] TYPE_INT32 = 2'h1;
    localparam logic [1:0] TYPE_FLOAT = 2'h2;
    localparam logic [1:0] TYPE_RSVD = 2'h3;
    localparam logic FLOAT_SUPPORTED = 1'b1;
    // ------------------------------------------------------------------
    // CRC-16 (x16+x15+x2+1, bit-reflected form)
    // ------------------------------------------------------------------
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    // ------------------------------------------------------------------
    // States and response kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DECODE = 3'b001,
        S_RD_REQ = 3'b010,
        S_RD_WAIT = 3'b011,
        S_WR_REQ = 3'b100,
        S_WR_WAIT = 3'b101,
        S_TX = 3'b110
    } mtr_state_e;
    typedef enum logic [1:0] {
        R_EXC = 2'b00,
        R_READ = 2'b01,
        R_ECHO = 2'b10,
        R_WRITTEN = 2'b11
    } mtr_resp_e;
endpackage : mtr_pkg

// [tb/mtr_handler_bench.sv]
// Self-checking bench for the typed register request handler
`timescale 1ns/1ps
module mtr_handler_bench;
    logic clk = 0, rst = 1, param_ack = 0, rx_valid, frame_end, frame_err, tx_ready;
    logic tx_valid, param_rd, param_wr, param_wide, param_float;
    logic [7:0] tx_data, rx_data;
    logic [13:0] param_index;
    logic [31:0] param_wr_data, wr_seen;
    int miscompares = 0, checked = 0, dly = 0;
    // Store: 127 is 32 bit, other indices up to 129 are 16 bit, above 129 missing
    wire fail = param_index > 14'h0081;
    wire is32 = param_index == 14'h007F;
    wire [31:0] rd = is32 ? 32'h12345678 : param_index == 14'h0080 ? 32'h0000ABCD : 32'h00000123;
    logic [47:0] rq[10] = '{48'h0803007F0001, 48'h0803407F0002, 48'h0803407F0001,
        48'h080340800002, 48'h0803407F0004, 48'h0805007F0001, 48'h0803C07F0002,
        48'h0806007FABCD, 48'h0803007F001F, 48'h0803807F0002};
    logic [87:0] rs[10] = '{88'h0803025678, 88'h08030412345678, 88'h088302,
        88'h080304FFFFABCD, 88'h08030812345678FFFFABCD, 88'h088501, 88'h088302,
        88'h0806007FABCD, 88'h088302, 88'h08030412345678};
    int n[10] = '{5, 7, 3, 7, 11, 3, 3, 6, 3, 7};
    // Block write whose second value fails, and the header of an oversized block
    logic [119:0] wq = 120'h0810408100040800000123_0000BEEF;
    logic [55:0] oq = 56'h08100000002040;
    logic [7:0] mq[$];
    always #5 clk = ~clk;
    mtr_handler i_mtr_handler (.clk(clk), .rst(rst), .node_addr(8'h08), .rx_valid(rx_valid),
        .rx_data(rx_data), .frame_end(frame_end), .frame_err(frame_err), .tx_ready(tx_ready),
        .param_ack(param_ack), .param_fail(fail), .param_is32(is32), .param_rd_data(rd),
        .tx_valid(tx_valid), .tx_data(tx_data), .param_rd(param_rd), .param_wr(param_wr),
        .param_index(param_index), .param_wr_data(param_wr_data), .param_wide(param_wide),
        .param_float(param_float));
    mtr_master_model i_mtr_master_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .frame_end(frame_end), .frame_err(frame_err), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data));
    // Store answers three cycles after each request
    always @(posedge clk) begin
        #1 param_ack = dly == 1;
        if (dly != 0) dly--;
        if (param_rd || param_wr) dly = 3;
        if (param_wr) wr_seen = param_wr_data;
    end
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, a, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // Send one request and compare the whole reply, or silence when n is 0
    task automatic runq(input logic [7:0] b[$], input logic [87:0] r, input int n, input bit bad,
        input bit err);
        logic [7:0] e[$];
        logic [15:0] c;
        int k;
        i_mtr_master_model.got.delete();
        for (int i = n - 1; i >= 0; i--) e.push_back(r[8*i +: 8]);
        i_mtr_master_model.send(b, bad, err);
        for (k = 0; k < 400 && (n == 0 || i_mtr_master_model.got.size() < n + 2); k++)
            @(posedge clk);
        if (k == 400 && n != 0) begin
            miscompares++;
            stop_test();
        end else begin
            c = i_mtr_master_model.crc(e);
            if (n != 0) e.push_back(c[7:0]);
            if (n != 0) e.push_back(c[15:8]);
            repeat (2) @(posedge clk);
            chk(i_mtr_master_model.got.size(), e.size());
            foreach (e[i]) if (i < i_mtr_master_model.got.size()) chk(i_mtr_master_model.got[i], e[i]);
            chk({31'h0, tx_valid}, 32'h0);
        end
    endtask : runq
    // Six-byte request taken from a row
    task automatic run(input logic [47:0] q, input logic [87:0] r, input int n, input bit bad,
        input bit err);
        logic [7:0] b[$];
        for (int i = 5; i >= 0; i--) b.push_back(q[8*i +: 8]);
        runq(b, r, n, bad, err);
    endtask : run
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        @(posedge clk) #1;
        chk({30'h0, tx_valid, param_rd}, 32'h0);
        for (int r = 0; r < 10; r++) run(rq[r], rs[r], n[r], 0, 0);
        chk({31'h0, param_float}, 32'h1);
        chk(wr_seen, 32'hFFFFABCD);
        run(48'h080600900001, 88'h088602, 3, 0, 0);
        run(48'h0803007F0001, 88'h0, 0, 1, 0);
        run(48'h0803007F0001, 88'h0, 0, 0, 1);
        run(48'h0903007F0001, 88'h0, 0, 0, 0);
        i_mtr_master_model.slow = 1;
        run(rq[4], rs[4], n[4], 0, 0);
        for (int i = 14; i >= 0; i--) mq.push_back(wq[8*i +: 8]);
        runq(mq, 88'h081040810002, 6, 0, 0);
        chk(wr_seen, 32'h0000BEEF);
        mq.delete();
        for (int i = 0; i < 71; i++) mq.push_back(i < 7 ? oq[55-8*i -: 8] : 8'h00);
        runq(mq, 88'h0, 0, 0, 0);
        // Reset while a read waits for the store: no reply may follow
        i_mtr_master_model.got.delete();
        mq.delete();
        for (int i = 5; i >= 0; i--) mq.push_back(rq[1][8*i +: 8]);
        i_mtr_master_model.send(mq, 0, 0);
        repeat (3) @(posedge clk);
        #1 rst = 1;
        @(posedge clk) #1;
        rst = 0;
        chk({30'h0, tx_valid, param_wr}, 32'h0);
        repeat (50) @(posedge clk);
        chk(i_mtr_master_model.got.size(), 32'h0);
        run(rq[0], rs[0], n[0], 0, 0);
        stop_test();
    end
endmodule : mtr_handler_bench

// [tb/mtr_master_model.sv]
// Master-side model: sends request frames and collects reply bytes
`timescale 1ns/1ps
module mtr_master_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic frame_end,
    output logic frame_err,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    logic [7:0] got[$];
    bit slow = 0;
    // Reflected CRC-16 over a byte list
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc
    // Bytes, CRC low then high, then the gap pulse
    task automatic send(input logic [7:0] b[$], input bit bad, input bit err);
        logic [15:0] c;
        c = crc(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge clk) #1;
            rx_valid = 1'b1;
            rx_data = b[i];
            frame_err = err && i == 2;
        end
        @(posedge clk) #1;
        rx_valid = 1'b0;
        rx_data = ~rx_data; // Released line does not keep its value
        frame_err = 1'b0;
        frame_end = 1'b1;
        @(posedge clk) #1;
        frame_end = 1'b0;
    endtask : send
    initial begin
        {rx_valid, frame_end, frame_err, tx_ready} = 4'h1;
        rx_data = 8'h00;
    end
    // Ready stalls on alternate cycles when slow
    always @(posedge clk) #1 tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
endmodule : mtr_master_model
